/* compare_pkg.sv */
// Contract
// - channel runs only while enable bit set
// - stop-in-idle set halts channel during idle
// - wide bit selects 32-bit versus 16-bit compare
// - fault flag set by fault, hardware-only clear
// - fault flag reads zero outside mode 111
// - timebase select one picks third timer
// - mode 111 gives PWM with fault input
// - mode 110 gives PWM, fault input ignored
// - mode 101 starts low, continuous pulses
// - mode 100 starts low, one pulse only
// - mode 011 toggles pin per compare event
// - mode 010 starts high, event drives low
// - mode 001 starts low, event drives high
// - mode 000 leaves compare inactive
// - unimplemented control bits read as zero
`default_nettype none
package compare_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRI  = 8'h04;
    localparam logic [7:0] OFS_SEC  = 8'h08;
    localparam logic [7:0] OFS_IST  = 8'h0C;
    localparam logic [7:0] OFS_IMSK = 8'h10;

    // decoded register selects
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_PRI  = 3'h1;
    localparam logic [2:0] SEL_SEC  = 3'h2;
    localparam logic [2:0] SEL_IST  = 3'h3;
    localparam logic [2:0] SEL_IMSK = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // control field positions
    localparam int BIT_ON   = 15;
    localparam int BIT_STOP_IN_IDLE = 13;
    localparam int BIT_WIDE = 5;
    localparam int BIT_FLT  = 4;
    localparam int BIT_TSEL = 3;

    // interrupt status layout
    localparam int IRQ_BITS = 2;
    localparam int IRQ_CMP  = 0;
    localparam int IRQ_FLT  = 1;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    localparam logic [1:0]  IRQ_RST     = 2'h0;

    typedef enum logic [2:0] {
        MODE_OFF       = 3'h0,
        MODE_SET_HI    = 3'h1,
        MODE_SET_LO    = 3'h2,
        MODE_TOGGLE    = 3'h3,
        MODE_ONE_PULSE = 3'h4,
        MODE_PULSES    = 3'h5,
        MODE_PWM       = 3'h6,
        MODE_PWM_FLT   = 3'h7
    } mode_t;

    typedef struct packed {
        logic  on;
        logic  stop_in_idle;
        logic  wide;
        logic  tsel;
        mode_t mode;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, MODE_OFF};

    typedef struct packed {
        logic [31:0] cnt;
        logic        roll;
    } tbase_t;

    typedef enum logic [1:0] {WR_COLLECT = 2'h1, WR_RESP = 2'h2} wr_st_t;
    typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_DATA = 2'h2} rd_st_t;

    // count equals compare value at the selected width
    function automatic logic hit(logic [31:0] c, logic [31:0] v, logic w);
        hit = w ? (c == v) : (c[15:0] == v[15:0]);
    endfunction

    function automatic logic [2:0] reg_sel(logic [7:0] a);
        case (a)
            OFS_CTRL: reg_sel = SEL_CTRL;
            OFS_PRI:  reg_sel = SEL_PRI;
            OFS_SEC:  reg_sel = SEL_SEC;
            OFS_IST:  reg_sel = SEL_IST;
            OFS_IMSK: reg_sel = SEL_IMSK;
            default:  reg_sel = SEL_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

/* compare_engine.sv */
`timescale 1ns/1ns
`default_nettype none
module compare_engine
    import compare_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // control
    input  wire logic        on,
    input  wire logic        halt,
    input  wire ctrl_t       ctrl,
    input  wire tbase_t      tb,
    input  wire logic [31:0] pri,
    input  wire logic [31:0] sec,
    input  wire logic        fault_in,
    // results
    output logic             pin_r,
    output logic             evt_r,
    output logic             fset_r,
    output logic             fault_r
);
    logic  pin_nxt, evt_nxt, fset_nxt, fault_nxt, done_r, done_nxt;
    mode_t pmode_r, pmode_nxt;
    logic  hit_p, hit_s;

    assign hit_p = hit(tb.cnt, pri, ctrl.wide);
    assign hit_s = hit(tb.cnt, sec, ctrl.wide);

    // pin sequencing; a mode change re-initialises the pin first
    always_comb begin
        pin_nxt = pin_r;
        done_nxt = done_r;
        pmode_nxt = pmode_r;
        fault_nxt = fault_r;
        evt_nxt = 1'b0;
        fset_nxt = 1'b0;
        if (!on) begin
            pin_nxt = 1'b0;
            done_nxt = 1'b0;
            pmode_nxt = MODE_OFF;
            fault_nxt = 1'b0;
        end else if (!halt) begin
            pmode_nxt = ctrl.mode;
            if (ctrl.mode != pmode_r) begin
                pin_nxt = (ctrl.mode == MODE_SET_LO);
                done_nxt = 1'b0;
            end else begin
                case (ctrl.mode)
                    MODE_SET_HI: if (hit_p) begin
                        pin_nxt = 1'b1;
                        evt_nxt = 1'b1;
                    end
                    MODE_SET_LO: if (hit_p) begin
                        pin_nxt = 1'b0;
                        evt_nxt = 1'b1;
                    end
                    MODE_TOGGLE: if (hit_p) begin
                        pin_nxt = !pin_r;
                        evt_nxt = 1'b1;
                    end
                    MODE_ONE_PULSE, MODE_PULSES: begin
                        if (hit_p && !done_r) begin
                            pin_nxt = 1'b1;
                            evt_nxt = 1'b1;
                        end
                        if (hit_s && pin_r) begin
                            pin_nxt = 1'b0;
                            done_nxt = (ctrl.mode == MODE_ONE_PULSE);
                        end
                    end
                    MODE_PWM, MODE_PWM_FLT: begin
                        evt_nxt = hit_s;
                        if (hit_s)
                            pin_nxt = 1'b0;
                        if (tb.roll)
                            pin_nxt = 1'b1;
                        if (ctrl.mode == MODE_PWM_FLT) begin
                            if (fault_in) begin
                                fault_nxt = 1'b1;
                                fset_nxt = !fault_r;
                            end else if (tb.roll) begin
                                fault_nxt = 1'b0;
                            end
                            if (fault_nxt)
                                pin_nxt = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_r <= 1'b0;
            done_r <= 1'b0;
            pmode_r <= MODE_OFF;
            fault_r <= 1'b0;
            evt_r <= 1'b0;
            fset_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
            done_r <= done_nxt;
            pmode_r <= pmode_nxt;
            fault_r <= fault_nxt;
            evt_r <= evt_nxt;
            fset_r <= fset_nxt;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic steady;
    assign steady = on && !halt && ctrl.mode == pmode_r;

    sequence s_pulse_end;
        steady && ctrl.mode == MODE_ONE_PULSE && hit_s && pin_r;
    endsequence

    a_off_low: assert property (!on |=> !pin_r)
        else $error("pin not low while disabled");
    a_idle_frozen: assert property (on && halt ##1 on |-> $stable(pin_r))
        else $error("pin moved while halted in idle");
    a_narrow_cmp: assert property (steady && ctrl.mode == MODE_SET_HI && !ctrl.wide
        && tb.cnt[15:0] == pri[15:0] |=> pin_r)
        else $error("low half match did not raise pin");
    a_fault_sticky: assert property (fault_r && on && !tb.roll |=> fault_r)
        else $error("fault flag cleared without rollover");
    a_fault_forces: assert property (steady && ctrl.mode == MODE_PWM_FLT && fault_in
        |=> !pin_r && fault_r)
        else $error("fault did not force pin low");
    a_pwm_rise: assert property (steady && ctrl.mode == MODE_PWM && tb.roll |=> pin_r)
        else $error("pwm did not rise at rollover");
    a_single_pulse: assert property (s_pulse_end ##1 (steady && !hit_s) |=> !pin_r)
        else $error("second pulse in single pulse mode");
    a_toggle_flip: assert property (steady && ctrl.mode == MODE_TOGGLE && hit_p
        |=> pin_r != $past(pin_r))
        else $error("toggle did not invert pin");
    a_force_low: assert property (steady && ctrl.mode == MODE_SET_LO && hit_p |=> !pin_r)
        else $error("compare did not force pin low");

endmodule
`default_nettype wire

/* output_compare_control.sv */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module output_compare_control
    import compare_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    // write data channel
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // write response channel
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // read address channel
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    // read data channel
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // device power state and time bases
    input  wire logic        device_idle,
    input  wire tbase_t      second_timer,
    input  wire tbase_t      third_timer,
    // pins
    input  wire logic        fault_pin,
    output logic             compare_output_pin,
    // interrupt
    output logic             irq
);

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(
        logic [31:0] old,
        logic [31:0] nw,
        logic [3:0]  st
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        merge = r;
    endfunction

    // control word image; fault bit only visible in mode 111
    function automatic logic [31:0] ctrl_word(ctrl_t c, logic f);
        logic [31:0] w;
        w = WORD_RST;
        w[BIT_ON] = c.on;
        w[BIT_STOP_IN_IDLE] = c.stop_in_idle;
        w[BIT_WIDE] = c.wide;
        w[BIT_FLT] = f && (c.mode == MODE_PWM_FLT);
        w[BIT_TSEL] = c.tsel;
        w[2:0] = c.mode;
        ctrl_word = w;
    endfunction

    // write channel state
    wr_st_t      wst_r;
    wr_st_t      wst_nxt;
    logic        aw_got_r;
    logic        aw_got_nxt;
    logic        w_got_r;
    logic        w_got_nxt;
    logic [7:0]  waddr_r;
    logic [7:0]  waddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0]  wstrb_r;
    logic [3:0]  wstrb_nxt;
    logic        awready_r;
    logic        awready_nxt;
    logic        wready_r;
    logic        wready_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        wr_en;
    logic [2:0]  wsel;

    // read channel state
    rd_st_t      rst_r;
    rd_st_t      rst_nxt;
    logic        arready_r;
    logic        arready_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;
    logic [2:0]  rsel;

    // register file
    ctrl_t         ctrl_r;
    ctrl_t         ctrl_nxt;
    logic [31:0]   pri_r;
    logic [31:0]   pri_nxt;
    logic [31:0]   sec_r;
    logic [31:0]   sec_nxt;
    logic [IRQ_BITS-1:0] ist_r;
    logic [IRQ_BITS-1:0] ist_nxt;
    logic [IRQ_BITS-1:0] imsk_r;
    logic [IRQ_BITS-1:0] imsk_nxt;
    logic [IRQ_BITS-1:0] ist_clr;
    logic          irq_r;
    logic          irq_nxt;
    logic [31:0]   wmerge;

    // fault pin synchroniser and engine hookup
    logic   fault_meta_r;
    logic   fault_sync_r;
    logic   halt;
    tbase_t tb_sel;
    logic   pin_r;
    logic   evt;
    logic   fset;
    logic   fault_flag;

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign irq = irq_r;
    assign compare_output_pin = pin_r;

    // idle comes from same-clock power logic, needs no sync
    assign halt = ctrl_r.stop_in_idle && device_idle;
    assign tb_sel = ctrl_r.tsel ? third_timer : second_timer;
    assign wsel = reg_sel(waddr_r);
    assign rsel = reg_sel(araddr);

    // write path: address and data taken in either order
    always_comb begin
        wst_nxt = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        wr_en = 1'b0;
        case (wst_r)
            WR_COLLECT: begin
                if (awvalid && awready_r) begin
                    aw_got_nxt = 1'b1;
                    waddr_nxt = awaddr;
                end
                if (wvalid && wready_r) begin
                    w_got_nxt = 1'b1;
                    wdata_nxt = wdata;
                    wstrb_nxt = wstrb;
                end
                if (aw_got_r && w_got_r) begin
                    wr_en = (wsel != SEL_NONE);
                    bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    bvalid_nxt = 1'b1;
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    wst_nxt = WR_RESP;
                end
            end
            WR_RESP: begin
                if (bready) begin
                    bvalid_nxt = 1'b0;
                    wst_nxt = WR_COLLECT;
                end
            end
            default: wst_nxt = WR_COLLECT;
        endcase
        awready_nxt = (wst_nxt == WR_COLLECT) && !aw_got_nxt;
        wready_nxt = (wst_nxt == WR_COLLECT) && !w_got_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r <= WR_COLLECT;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= OFS_CTRL;
            wdata_r <= WORD_RST;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            wst_r <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // read path: data snapshot taken at address acceptance
    always_comb begin
        rst_nxt = rst_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rst_r)
            RD_IDLE: begin
                if (arvalid && arready_r) begin
                    rvalid_nxt = 1'b1;
                    rresp_nxt = RESP_OKAY;
                    rst_nxt = RD_DATA;
                    case (rsel)
                        SEL_CTRL: rdata_nxt = ctrl_word(ctrl_r, fault_flag);
                        SEL_PRI:  rdata_nxt = pri_r;
                        SEL_SEC:  rdata_nxt = sec_r;
                        SEL_IST:  rdata_nxt = {30'h0, ist_r};
                        SEL_IMSK: rdata_nxt = {30'h0, imsk_r};
                        default: begin
                            rdata_nxt = WORD_RST;
                            rresp_nxt = RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_DATA: begin
                if (rready) begin
                    rvalid_nxt = 1'b0;
                    rst_nxt = RD_IDLE;
                end
            end
            default: rst_nxt = RD_IDLE;
        endcase
        arready_nxt = (rst_nxt == RD_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_r <= RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= WORD_RST;
            rresp_r <= RESP_OKAY;
        end else begin
            rst_r <= rst_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // register updates; the fault status bit is never written
    always_comb begin
        ctrl_nxt = ctrl_r;
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        imsk_nxt = imsk_r;
        ist_clr = '0;
        wmerge = merge(ctrl_word(ctrl_r, 1'b0), wdata_r, wstrb_r);
        if (wr_en) begin
            case (wsel)
                SEL_CTRL: begin
                    ctrl_nxt.on = wmerge[BIT_ON];
                    ctrl_nxt.stop_in_idle = wmerge[BIT_STOP_IN_IDLE];
                    ctrl_nxt.wide = wmerge[BIT_WIDE];
                    ctrl_nxt.tsel = wmerge[BIT_TSEL];
                    ctrl_nxt.mode = mode_t'(wmerge[2:0]);
                end
                SEL_PRI:  pri_nxt = merge(pri_r, wdata_r, wstrb_r);
                SEL_SEC:  sec_nxt = merge(sec_r, wdata_r, wstrb_r);
                SEL_IST:  ist_clr = wdata_r[IRQ_BITS-1:0] & {IRQ_BITS{wstrb_r[0]}};
                SEL_IMSK: begin
                    if (wstrb_r[0])
                        imsk_nxt = wdata_r[IRQ_BITS-1:0];
                end
                default: ;
            endcase
        end
        // a new event outranks a clear in the same cycle
        ist_nxt = (ist_r & ~ist_clr) | {fset, evt};
        irq_nxt = |(ist_r & imsk_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            pri_r <= WORD_RST;
            sec_r <= WORD_RST;
            ist_r <= IRQ_RST;
            imsk_r <= IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pri_r <= pri_nxt;
            sec_r <= sec_nxt;
            ist_r <= ist_nxt;
            imsk_r <= imsk_nxt;
            irq_r <= irq_nxt;
        end
    end

    // fault pin is asynchronous; only the second stage is used
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_meta_r <= 1'b0;
            fault_sync_r <= 1'b0;
        end else begin
            fault_meta_r <= fault_pin;
            fault_sync_r <= fault_meta_r;
        end
    end

    compare_engine u_engine (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .on       (ctrl_r.on),
        .halt     (halt),
        .ctrl     (ctrl_r),
        .tb       (tb_sel),
        .pri      (pri_r),
        .sec      (sec_r),
        .fault_in (fault_sync_r),
        .pin_r    (pin_r),
        .evt_r    (evt),
        .fset_r   (fset),
        .fault_r  (fault_flag)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_ctrl_r;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_ctrl_r <= 1'b0;
        else if (arvalid && arready_r)
            rd_ctrl_r <= (rsel == SEL_CTRL);
    end

    a_fault_hidden: assert property ($rose(rvalid_r) && rd_ctrl_r
        && $past(ctrl_r.mode) != MODE_PWM_FLT |-> !rdata_r[BIT_FLT])
        else $error("fault bit visible outside mode 111");
    a_unused_zero: assert property ($rose(rvalid_r) && rd_ctrl_r
        |-> rdata_r[31:16] == 16'h0000 && !rdata_r[14] && rdata_r[12:6] == 7'h00)
        else $error("unimplemented control bits not zero");
    a_tsel_route: assert property (ctrl_r.on && !halt && !$past(halt) && $past(ctrl_r.on)
        && ctrl_r.tsel && ctrl_r.mode == MODE_SET_HI && $past(ctrl_r.mode) == MODE_SET_HI
        && hit(third_timer.cnt, pri_r, ctrl_r.wide) |=> pin_r) else $error("tsel hit missed");

endmodule
`default_nettype wire

/* fault_source.sv */
`timescale 1ns/1ns
`default_nettype none
module fault_source (
    // clock
    input  wire logic aclk,
    // request from the bench, line to the block
    input  wire logic fault_req,
    output logic      fault_line
);
    // the external circuit switches its fault line from a flop
    always_ff @(posedge aclk) begin
        fault_line <= fault_req;
    end
endmodule
`default_nettype wire

/* output_compare_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module output_compare_control_bench;
    import compare_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, pin, irq;
    logic        device_idle, fault_req, fault_line;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic [3:0]  wstrb, tcnt;
    logic [1:0]  bresp, rresp, resp_q;
    tbase_t      t2, t3;
    int          failures, checked, cyc;
    // per case: control word, pin at tcnt D,8,E then 8,E
    localparam logic [15:0] CW [10] = '{16'h8000, 16'h8001, 16'h8002, 16'h8003,
        16'h8004, 16'h8005, 16'h8006, 16'h0001, 16'h8021, 16'h8009};
    localparam logic [4:0] EX [10] = '{5'h00, 5'h0F, 5'h10, 5'h0C, 5'h08, 5'h0A,
        5'h0A, 5'h00, 5'h00, 5'h07};

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // third timer runs 12 counts ahead so the two bases differ
    assign t2 = {28'h0, tcnt, tcnt == 4'hF};
    assign t3 = {28'h0, tcnt + 4'hC, tcnt == 4'hF};
    // timers and hang guard
    always @(posedge aclk) begin
        tcnt <= tcnt + 4'h1;
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            end_sim;
        end
    end

    output_compare_control dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .device_idle(device_idle), .second_timer(t2), .third_timer(t3),
        .fault_pin(fault_line), .compare_output_pin(pin), .irq(irq));
    fault_source load (.aclk(aclk), .fault_req(fault_req), .fault_line(fault_line));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic at(input logic [3:0] v);
        do @(posedge aclk); while (tcnt !== v);
    endtask
    // one edge first so no signal is driven twice in a time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp_q = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
    endtask

    task automatic t_bus;
        rd(OFS_CTRL);
        chk(rd_q, 32'h0, "ctrl reset");
        chk({30'h0, resp_q}, {30'h0, RESP_OKAY}, "rd okay");
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        chk({30'h0, resp_q}, {30'h0, RESP_OKAY}, "wr okay");
        rd(OFS_CTRL);
        chk(rd_q, 32'h0000_A02F, "ctrl bits");
        rd(8'h14);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR}, "unmapped");
        wr(8'h14, 32'h0);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR}, "wr unmapped");
        $display("bus test done");
    endtask
    task automatic t_modes;
        logic [4:0] got;
        wr(OFS_PRI, 32'h0001_0004);
        wr(OFS_SEC, 32'h0000_000A);
        for (int i = 0; i < 10; i++) begin
            wr(OFS_CTRL, 32'h0);
            at(4'h6);
            wr(OFS_CTRL, {16'h0, CW[i]});
            at(4'hD);
            got[4] = pin;
            at(4'h8);
            got[3] = pin;
            at(4'hE);
            got[2] = pin;
            at(4'h8);
            got[1] = pin;
            at(4'hE);
            got[0] = pin;
            chk({27'h0, got}, {27'h0, EX[i]}, "pin trace");
        end
        $display("mode test done");
    endtask
    task automatic t_fault;
        wr(OFS_CTRL, 32'h0000_8007);
        at(4'h8);
        at(4'h8); // a full period, so a rollover has raised the pin
        chk(32'(pin), 32'h1, "pwm high");
        fault_req <= 1'b1;
        repeat (10) @(posedge aclk); // past a rollover: only the fault keeps the pin low
        chk(32'(pin), 32'h0, "fault low");
        rd(OFS_CTRL);
        chk(rd_q, 32'h0000_8017, "flag set");
        wr(OFS_CTRL, 32'h0000_8007);
        rd(OFS_CTRL);
        chk(rd_q, 32'h0000_8017, "flag kept");
        wr(OFS_CTRL, 32'h0000_8006);
        rd(OFS_CTRL);
        chk(rd_q, 32'h0000_8006, "flag hidden");
        fault_req <= 1'b0;
        wr(OFS_CTRL, 32'h0000_8007);
        at(4'hF);
        at(4'hF);
        rd(OFS_CTRL);
        chk(rd_q, 32'h0000_8007, "flag cleared");
        $display("fault test done");
    endtask
    task automatic t_irq;
        wr(OFS_CTRL, 32'h0000_8000);
        wr(OFS_IMSK, 32'h0);
        wr(OFS_IST, 32'h3);
        rd(OFS_IST);
        chk(rd_q, 32'h0, "status clear");
        wr(OFS_CTRL, 32'h0000_8001);
        at(4'h5); // a full steady period covers the count 4 match
        at(4'h5);
        rd(OFS_IST);
        chk(rd_q, 32'h1, "event");
        chk(32'(irq), 32'h0, "masked");
        wr(OFS_IMSK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1, "irq high");
        wr(OFS_CTRL, 32'h0000_8000);
        wr(OFS_IST, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0, "irq low");
        $display("irq test done");
    endtask
    task automatic t_idle;
        wr(OFS_CTRL, 32'h0);
        at(4'hA);
        wr(OFS_CTRL, 32'h0000_A001);
        device_idle <= 1'b1;
        at(4'h8);
        chk(32'(pin), 32'h0, "frozen");
        device_idle <= 1'b0;
        at(4'h8);
        chk(32'(pin), 32'h1, "resumed");
        $display("idle test done");
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {device_idle, fault_req, awaddr, araddr, wdata, wstrb, tcnt} = '0;
        {failures, checked, cyc} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_bus;
        t_modes;
        t_fault;
        t_irq;
        t_idle;
        end_sim;
    end
endmodule
`default_nettype wire
